// File: common/sft_pkg.sv
// Constants, types and helpers shared by the serial frame transmitter
package sft_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_FORMAT = 3'h3;
  localparam logic [2:0] REG_BAUD_LO = 3'h4;
  localparam logic [2:0] REG_BAUD_HI = 3'h5;

  // Status fields
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_TXC_BIT = 1;
  localparam int ST_FE_BIT = 2;

  // Control fields
  localparam int CT_TXEN_BIT = 0;
  localparam int CT_NINTH_BIT = 1;
  localparam int CT_DOUBLE_BIT = 2;
  localparam int CT_SYNC_BIT = 3;
  localparam int CT_MASTER_BIT = 4;
  localparam int CTRL_W = 5;

  // Format fields
  localparam int FM_SIZE_LSB = 0;
  localparam int FM_PAR_LSB = 4;
  localparam int FM_STOP_BIT = 6;
  localparam int FMT_W = 7;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [FMT_W-1:0] FMT_RESET = 7'h03;
  localparam logic [11:0] BAUD_RESET = 12'h000;

  // ********************************
  // Format encodings
  // ********************************
  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_9 = 3'h7;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam int FRAME_MAX = 13;

  // ********************************
  // Bit rate dividers
  // ********************************
  localparam int DIV_NORMAL = 16;
  localparam int DIV_DOUBLE = 8;
  localparam int DIV_SYNC = 2;
  localparam logic [3:0] LAST_NORMAL = 4'(DIV_NORMAL - 1);
  localparam logic [3:0] LAST_DOUBLE = 4'(DIV_DOUBLE - 1);
  localparam logic [3:0] MID_NORMAL = 4'(DIV_NORMAL / 2);
  localparam logic [3:0] MID_DOUBLE = 4'(DIV_DOUBLE / 2);

  typedef enum logic {ST_IDLE, ST_SHIFT} sft_state_type;

  // Number of data bits for a size code
  function automatic logic [3:0] data_bits(input logic [2:0] size);
    if (size == SIZE_9) begin
      return 4'h9;
    end
    return 4'h5 + {2'h0, size[1:0]};
  endfunction

  // Index of the first stop bit in a frame
  function automatic logic [3:0] first_stop(input logic [FMT_W-1:0] fmt);
    return 4'h1 + data_bits(fmt[FM_SIZE_LSB +: 3]) + {3'h0, fmt[FM_PAR_LSB+1]};
  endfunction

endpackage

// File: hdl/sft_baud.sv
// Baud rate down-counter that emits one tick every divisor plus one clocks
`timescale 1ns/1ps
module sft_baud
  import sft_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic [11:0] divisor,
  input wire logic reload,
  // Tick
  output logic tick
);

  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic [12:0] gap_r;
  logic [12:0] gap_nxt;

  always_comb begin
    cnt_nxt = cnt_r - 12'h001;
    if (reload || cnt_r == 12'h000) begin
      cnt_nxt = divisor;
    end
  end

  assign tick = (cnt_r == 12'h000);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ********************************
  // Checks
  // ********************************
  always_comb begin
    gap_nxt = gap_r + 13'h0001;
    if (tick || reload) begin
      gap_nxt = 13'h0000;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 13'h1FFF;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (!arst_n)
    tick && gap_r != 13'h1FFF && !$past(reload) && $stable(divisor)
      |-> gap_r == {1'b0, divisor})
    else $error("baud tick spacing differs from divisor plus one");

endmodule

// File: hdl/sft_tx.sv
// Serial frame transmitter with register port, pin takeover and stop bit check
`timescale 1ns/1ps
module sft_tx
  import sft_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // Complete flag clear from interrupt entry
  input wire logic TXC_ACK,
  // Ordinary port control of the serial pin
  input wire logic PORT_O,
  input wire logic PORT_OE,
  // Serial output pin
  input wire logic SER_I,
  output logic SER_O,
  output logic SER_OE,
  // Transfer clock pin
  input wire logic XCK_I,
  output logic XCK_O,
  output logic XCK_OE
);

  // ********************************
  // Declarations
  // ********************************
  logic [8:0] buf_r, buf_nxt;
  logic empty_r, empty_nxt;
  logic txc_r, txc_nxt;
  logic fe_r, fe_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [FMT_W-1:0] fmt_r, fmt_nxt;
  logic [11:0] baud_r, baud_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  sft_state_type state_r, state_nxt;
  logic [FRAME_MAX-1:0] shift_r, shift_nxt;
  logic [3:0] pos_r, pos_nxt;
  logic [3:0] presc_r, presc_nxt;
  logic xck_r, xck_nxt;
  logic ser_r, ser_nxt;
  logic take_r, take_nxt;
  logic xck_s1, xck_s2, xck_s3;
  logic in_s1, in_s2;
  logic baud_tick, bit_tick, sample, load, frame_end, data_wr;
  logic tx_en, sync_mode, master;
  logic [3:0] presc_last, presc_mid, nbits, stop_pos, frame_last;

  // Frame vector, bit 0 is the start bit
  function automatic logic [FRAME_MAX-1:0] build_frame(input logic [8:0] d,
                                                       input logic [FMT_W-1:0] fmt);
    logic [FRAME_MAX-1:0] v;
    logic [3:0] n;
    logic par;
    v = '1;
    n = data_bits(fmt[FM_SIZE_LSB +: 3]);
    par = fmt[FM_PAR_LSB] & fmt[FM_PAR_LSB+1];
    v[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        v[1+i] = d[i];
        par = par ^ d[i];
      end
    end
    if (fmt[FM_PAR_LSB+1]) begin
      v[4'h1 + n] = par;
    end
    return v;
  endfunction

  assign data_wr = WR && ADDR == REG_DATA;
  assign tx_en = ctrl_r[CT_TXEN_BIT];
  assign sync_mode = ctrl_r[CT_SYNC_BIT];
  assign master = ctrl_r[CT_MASTER_BIT];

  // ********************************
  // Bit timing
  // ********************************
  sft_baud u_baud (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .divisor(baud_nxt),
    .reload(WR && ADDR == REG_BAUD_LO),
    .tick(baud_tick)
  );

  always_comb begin
    presc_last = ctrl_r[CT_DOUBLE_BIT] ? LAST_DOUBLE : LAST_NORMAL;
    presc_mid = ctrl_r[CT_DOUBLE_BIT] ? MID_DOUBLE : MID_NORMAL;
    if (!sync_mode) begin
      bit_tick = baud_tick && presc_r == presc_last;
      sample = baud_tick && presc_r == presc_mid;
    end else if (master) begin
      bit_tick = baud_tick && !xck_r;
      sample = baud_tick && xck_r;
    end else begin
      bit_tick = xck_s2 && !xck_s3;
      sample = !xck_s2 && xck_s3;
    end
  end

  always_comb begin
    presc_nxt = presc_r;
    xck_nxt = xck_r;
    if (load && state_r == ST_IDLE) begin
      presc_nxt = 4'h0;
    end else if (baud_tick) begin
      presc_nxt = (presc_r == presc_last) ? 4'h0 : presc_r + 4'h1;
    end
    if (!(sync_mode && master)) begin
      xck_nxt = 1'b0;
    end else if (baud_tick) begin
      xck_nxt = !xck_r;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_r <= 4'h0;
      xck_r <= 1'b0;
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
      in_s1 <= 1'b1;
      in_s2 <= 1'b1;
    end else begin
      presc_r <= presc_nxt;
      xck_r <= xck_nxt;
      xck_s1 <= XCK_I;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
      in_s1 <= SER_I;
      in_s2 <= in_s1;
    end
  end

  // ********************************
  // Frame shifter
  // ********************************
  always_comb begin
    nbits = data_bits(fmt_r[FM_SIZE_LSB +: 3]);
    stop_pos = first_stop(fmt_r);
    frame_last = stop_pos + {3'h0, fmt_r[FM_STOP_BIT]};
    frame_end = state_r == ST_SHIFT && bit_tick && pos_r == frame_last;
    // Synchronous frames open on a transfer clock edge
    load = !empty_r && ((state_r == ST_IDLE && tx_en && (!sync_mode || bit_tick))
      || frame_end);
  end

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    pos_nxt = pos_r;
    case (state_r)
      ST_IDLE: begin
        if (load) begin
          state_nxt = ST_SHIFT;
          shift_nxt = build_frame(buf_r, fmt_r);
          pos_nxt = 4'h0;
        end
      end
      ST_SHIFT: begin
        if (load) begin
          shift_nxt = build_frame(buf_r, fmt_r);
          pos_nxt = 4'h0;
        end else if (frame_end) begin
          state_nxt = ST_IDLE;
        end else if (bit_tick) begin
          shift_nxt = {1'b1, shift_r[FRAME_MAX-1:1]};
          pos_nxt = pos_r + 4'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    take_nxt = tx_en || state_nxt == ST_SHIFT;
    ser_nxt = PORT_O;
    if (take_nxt) begin
      ser_nxt = (state_nxt == ST_SHIFT) ? shift_nxt[0] : 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= ST_IDLE;
      shift_r <= '1;
      pos_r <= 4'h0;
      ser_r <= 1'b1;
      take_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      pos_r <= pos_nxt;
      ser_r <= ser_nxt;
      take_r <= take_nxt;
    end
  end

  assign SER_O = ser_r;
  assign SER_OE = take_r || PORT_OE;
  assign XCK_O = xck_r;
  assign XCK_OE = tx_en && sync_mode && master;

  // ********************************
  // Registers and flags
  // ********************************
  always_comb begin
    buf_nxt = buf_r;
    empty_nxt = empty_r;
    txc_nxt = txc_r;
    fe_nxt = fe_r;
    ctrl_nxt = ctrl_r;
    fmt_nxt = fmt_r;
    baud_nxt = baud_r;
    rdata_nxt = '0;
    if (load) begin
      empty_nxt = 1'b1;
    end
    if (data_wr) begin
      buf_nxt = {ctrl_r[CT_NINTH_BIT], WDATA};
      empty_nxt = 1'b0;
    end
    if (WR && ADDR == REG_STATUS) begin
      txc_nxt = txc_r && !WDATA[ST_TXC_BIT];
      fe_nxt = fe_r && !WDATA[ST_FE_BIT];
    end
    if (TXC_ACK) begin
      txc_nxt = 1'b0;
    end
    if (frame_end && empty_r) begin
      txc_nxt = 1'b1;
    end
    if (state_r == ST_SHIFT && sample && pos_r == stop_pos && !in_s2) begin
      fe_nxt = 1'b1;
    end
    if (WR && ADDR == REG_CTRL) begin
      ctrl_nxt = WDATA[CTRL_W-1:0];
    end
    if (WR && ADDR == REG_FORMAT) begin
      fmt_nxt = WDATA[FMT_W-1:0];
    end
    if (WR && ADDR == REG_BAUD_LO) begin
      baud_nxt[7:0] = WDATA;
    end
    if (WR && ADDR == REG_BAUD_HI) begin
      baud_nxt[11:8] = WDATA[3:0];
    end
    if (RD) begin
      case (ADDR)
        REG_DATA: rdata_nxt = buf_r[7:0];
        REG_STATUS: rdata_nxt = {5'h00, fe_r, txc_r, empty_r};
        REG_CTRL: rdata_nxt = {3'h0, ctrl_r};
        REG_FORMAT: rdata_nxt = {1'b0, fmt_r};
        REG_BAUD_LO: rdata_nxt = baud_r[7:0];
        REG_BAUD_HI: rdata_nxt = {4'h0, baud_r[11:8]};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_r <= 9'h000;
      empty_r <= 1'b1;
      txc_r <= 1'b0;
      fe_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
      fmt_r <= FMT_RESET;
      baud_r <= BAUD_RESET;
      rdata_r <= '0;
    end else begin
      buf_r <= buf_nxt;
      empty_r <= empty_nxt;
      txc_r <= txc_nxt;
      fe_r <= fe_nxt;
      ctrl_r <= ctrl_nxt;
      fmt_r <= fmt_nxt;
      baud_r <= baud_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  sequence load_s;
    load && tx_en;
  endsequence

  sequence start_bit_s;
    state_r == ST_SHIFT && pos_r == 4'h0 && ser_r == 1'b0;
  endsequence

  start_low_a: assert property (load_s |=> start_bit_s)
    else $error("frame did not open with a low start bit");
  stop_high_a: assert property (
    state_r == ST_SHIFT && take_r && pos_r >= stop_pos && pos_r <= frame_last
      && $stable(fmt_r) |-> ser_r == 1'b1)
    else $error("stop bit not high");
  idle_high_a: assert property (state_r == ST_IDLE && take_r |-> ser_r)
    else $error("idle line not high");
  empty_clear_a: assert property (data_wr |=> !empty_r)
    else $error("data write did not clear empty flag");
  empty_set_a: assert property (load && !data_wr |=> empty_r ##0 state_r == ST_SHIFT)
    else $error("load did not set empty flag");
  load_now_a: assert property (
    state_r == ST_IDLE && !empty_r && tx_en && (!sync_mode || bit_tick)
      |=> state_r == ST_SHIFT && pos_r == 4'h0)
    else $error("idle shifter did not load at once");
  sync_align_a: assert property (
    state_r == ST_IDLE && sync_mode && !bit_tick |=> state_r == ST_IDLE)
    else $error("synchronous frame started off the transfer clock edge");
  txc_set_a: assert property (frame_end && empty_r |=> txc_r ##0 state_r == ST_IDLE)
    else $error("complete flag not set at frame end");
  parity_bit_a: assert property (
    load && fmt_r[FM_PAR_LSB+1] |=> shift_r[4'h1 + $past(nbits)]
      == ((^($past(buf_r) & ~(9'h1FF << $past(nbits)))) ^ $past(fmt_r[FM_PAR_LSB])))
    else $error("parity bit wrong");
  pin_take_a: assert property (tx_en |=> SER_OE)
    else $error("serial pin not taken over");
  xck_take_a: assert property (tx_en && sync_mode && master |-> XCK_OE)
    else $error("transfer clock pin not taken over");
  fe_check_a: assert property (
    state_r == ST_SHIFT && sample && pos_r > stop_pos && !fe_r
      && !(WR && ADDR == REG_STATUS) |=> !fe_r)
    else $error("second stop bit raised a frame error");

endmodule

// File: tb/sft_rx_model.sv
// Behavioural remote receiver that samples the serial line mid-bit
`timescale 1ns/1ps
module sft_rx_model (
  // Clock and line
  input wire logic clk,
  input wire logic line,
  // Frame shape
  input wire logic [7:0] bit_clk,
  input wire logic [3:0] nbits,
  // Captured frame
  output logic [15:0] frame,
  output logic [7:0] seen
);
  // ********************************
  // Frame capture
  // ********************************
  initial begin
    frame = 16'h0000;
    seen = 8'h00;
  end

  always begin
    @(negedge line);
    frame = 16'h0000;
    repeat (bit_clk / 2) @(posedge clk);
    for (int i = 0; i < int'(nbits); i++) begin
      frame[i] = line;
      if (i < int'(nbits) - 1) begin
        repeat (bit_clk) @(posedge clk);
      end
    end
    seen = seen + 8'h01;
  end
endmodule

// File: tb/testbench.sv
// Self-checking testbench for the serial frame transmitter
`timescale 1ns/1ps
module testbench
  import sft_pkg::*;
;
  logic clock, arst_n, wr_en, rd_en, txc_ack, port_o, port_oe, jam;
  logic xck_i = 1'b0;
  logic xck_prev;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic ser_o, ser_oe, xck_o, xck_oe;
  wire logic ser_line;
  logic [7:0] bit_clk;
  logic [3:0] nbits;
  logic [15:0] frame, expf;
  logic [7:0] seen, n0;
  int n_mismatch, checks_done;
  logic [6:0] t_fmt [9] = '{7'h03, 7'h00, 7'h21, 7'h72, 7'h07, 7'h03, 7'h03, 7'h37, 7'h03};
  logic [4:0] t_ctl [9] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h03, 5'h05, 5'h19, 5'h01, 5'h09};
  logic [7:0] t_div [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00};
  logic [7:0] t_bit [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h08, 8'h10, 8'h08};
  logic [8:0] t_dat [9] = '{9'h0A5, 9'h0FF, 9'h00B, 9'h055, 9'h1C3, 9'h0A5, 9'h05A, 9'h0F0,
    9'h03C};

  // Pull-up on the line, jam pulls it low
  assign ser_line = (ser_oe ? ser_o : 1'b1) & ~jam;

  sft_tx dut (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_en),
    .RD(rd_en), .RDATA(rdata), .TXC_ACK(txc_ack), .PORT_O(port_o), .PORT_OE(port_oe),
    .SER_I(ser_line), .SER_O(ser_o), .SER_OE(ser_oe), .XCK_I(xck_i), .XCK_O(xck_o),
    .XCK_OE(xck_oe));

  sft_rx_model partner (.clk(clock), .line(ser_line), .bit_clk(bit_clk), .nbits(nbits),
    .frame(frame), .seen(seen));

  // ********************************
  // Compare and bus tasks
  // ********************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: frame got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: pin got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask

  task automatic wait_frames(input logic [7:0] n);
    for (int c = 0; c < 4000 && seen !== n; c++) begin
      @(posedge clock);
    end
    chk8(seen, n);
  endtask

  task automatic config_fmt(input logic [6:0] f, input logic [4:0] c, input logic [7:0] dv);
    reg_wr(REG_BAUD_HI, 8'h00);
    reg_wr(REG_BAUD_LO, dv);
    reg_wr(REG_FORMAT, {1'h0, f});
    reg_wr(REG_CTRL, {3'h0, c});
  endtask

  task automatic jam_frame(input int k);
    n0 = seen;
    reg_wr(REG_DATA, 8'h15);
    repeat (5 + 16 * k) @(posedge clock);
    jam <= 1'b1;
    repeat (10) @(posedge clock);
    jam <= 1'b0;
    wait_frames(n0 + 8'h01);
    repeat (40) @(posedge clock);
  endtask

  function automatic logic [15:0] exp_frame(input logic [6:0] fmt, input logic [8:0] d,
                                            output logic [3:0] nb);
    logic [15:0] f;
    int nd;
    int k;
    logic p;
    f = 16'h0000;
    nd = (fmt[2:0] == 3'h7) ? 9 : int'(fmt[1:0]) + 5;
    k = 1;
    p = fmt[4];
    for (int i = 0; i < nd; i++) begin
      f[k] = d[i];
      p = p ^ d[i];
      k++;
    end
    if (fmt[5]) begin
      f[k] = p;
      k++;
    end
    f[k] = 1'b1;
    f[k+1] = fmt[6];
    nb = 4'(k + 1 + int'(fmt[6]));
    return f;
  endfunction

  task tally_and_finish;
    $display("counts: mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********************************
  // Clock, reset and watchdog
  // ********************************
  initial begin
    clock = 1'b0;
  end

  always #5 clock = ~clock;

  // Remote transfer clock for slave synchronous mode
  always begin
    repeat (4) @(posedge clock);
    xck_i <= ~xck_i;
  end

  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  // ********************************
  // Tests
  // ********************************
  initial begin
    {arst_n, wr_en, rd_en, txc_ack, port_o, port_oe, jam} = 7'h00;
    addr = 3'h0;
    wdata = 8'h00;
    bit_clk = 8'h10;
    nbits = 4'hA;
    n_mismatch = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk1(ser_oe, 1'b0);
    chk1(ser_o, 1'b0);
    port_o <= 1'b1;
    repeat (2) @(posedge clock);
    port_oe <= 1'b1;
    @(posedge clock);
    #1;
    chk1(ser_oe, 1'b1);
    port_oe <= 1'b0;
    reg_rd(REG_STATUS, 8'h01);
    reg_rd(REG_CTRL, 8'h00);
    reg_rd(REG_FORMAT, 8'h03);
    reg_rd(REG_BAUD_LO, 8'h00);
    reg_rd(3'h6, 8'h00);
    reg_wr(3'h7, 8'hFF);
    reg_rd(3'h7, 8'h00);
    for (int i = 0; i < 9; i++) begin
      config_fmt(t_fmt[i], t_ctl[i], t_div[i]);
      @(posedge clock);
      #1;
      chk1(ser_oe, 1'b1);
      chk1(xck_oe, t_ctl[i][3] & t_ctl[i][4]);
      xck_prev = xck_o;
      repeat (int'(t_div[i]) + 1) @(posedge clock);
      #1;
      chk1(xck_o, t_ctl[i][3] & t_ctl[i][4] & ~xck_prev);
      expf = exp_frame(t_fmt[i], t_dat[i], nbits);
      bit_clk <= t_bit[i];
      n0 = seen;
      reg_wr(REG_STATUS, 8'h02);
      reg_wr(REG_DATA, t_dat[i][7:0]);
      wait_frames(n0 + 8'h01);
      chk16(frame, expf);
      repeat (40) @(posedge clock);
      reg_rd(REG_STATUS, 8'h03);
      chk1(ser_line, 1'b1);
    end
    config_fmt(7'h03, 5'h01, 8'h00);
    bit_clk <= 8'h10;
    expf = exp_frame(7'h03, 9'h022, nbits);
    n0 = seen;
    reg_wr(REG_STATUS, 8'h02);
    reg_wr(REG_DATA, 8'h11);
    reg_wr(REG_DATA, 8'h22);
    reg_rd(REG_STATUS, 8'h00);
    wait_frames(n0 + 8'h02);
    chk16(frame, expf);
    reg_rd(REG_DATA, 8'h22);
    repeat (40) @(posedge clock);
    reg_rd(REG_STATUS, 8'h03);
    @(posedge clock);
    txc_ack <= 1'b1;
    @(posedge clock);
    txc_ack <= 1'b0;
    reg_rd(REG_STATUS, 8'h01);
    config_fmt(7'h40, 5'h01, 8'h00);
    expf = exp_frame(7'h40, 9'h015, nbits);
    jam_frame(7);
    reg_rd(REG_STATUS, 8'h03);
    jam_frame(6);
    reg_rd(REG_STATUS, 8'h07);
    reg_wr(REG_STATUS, 8'h04);
    reg_rd(REG_STATUS, 8'h03);
    tally_and_finish();
  end
endmodule
